// File: hw/sfe_erase_seq.sv
// Erase command sequencer: decodes finished frames, checks the write enable
// latch and sector protection, runs the self-timed erase and reports status.
// Assumes the array erases on o_erase_go and reports a verify failure on
// i_erase_fail in the system clock domain, valid on the timer's last cycle.
`timescale 1ns/100ps
module sfe_erase_seq import sfe_pkg::*; #(
   parameter int unsigned PAGE_ERASE_CYC = PAGE_ERASE_TIME_US * CLK_PER_US,
   parameter int unsigned BLK4K_ERASE_CYC = BLK4K_ERASE_TIME_US * CLK_PER_US,
   parameter int unsigned BLK32K_ERASE_CYC = BLK32K_ERASE_TIME_US * CLK_PER_US,
   parameter int unsigned BLK64K_ERASE_CYC = BLK64K_ERASE_TIME_US * CLK_PER_US,
   parameter int unsigned CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CLK_PER_US
) (
   // System clock and reset.
   input wire logic i_clk,
   input wire logic i_rstn,
   // Serial link.
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   // Status.
   output logic o_busy,
   output logic o_write_enable_latch,
   output logic o_erase_program_error_flag,
   // Sector protection.
   input wire logic i_prot_wr,
   input wire logic [NUM_SECT-1:0] i_prot_val,
   output logic [NUM_SECT-1:0] o_sector_prot,
   // Memory array erase port.
   output logic o_erase_go,
   output logic [ADDR_W-1:0] o_erase_base,
   output logic [2:0] o_erase_size,
   input wire logic i_erase_fail
);
   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_d;
      logic tg_m;
      logic tg_s;
      logic tg_seen;
      logic as_m;
      logic as_s;
      sfe_state_t st;
      logic write_enable_latch;
      logic erase_program_error_flag;
      logic [NUM_SECT-1:0] prot;
      logic go;
      logic [ADDR_W-1:0] base;
      sfe_size_t size;
      logic so;
      logic so_oe;
   } sfe_seq_t;

   sfe_seq_t s_r;
   sfe_seq_t s_nxt;
   sfe_frame_if frm ();
   logic tmr_done;
   logic [31:0] tmr_cycles;
   logic cs_rise;
   logic new_frame;
   logic aligned;
   logic [7:0] op;
   logic [2:0] nb;
   logic is_page;
   logic is_blk;
   logic is_chip;
   logic is_addr_erase;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] page_addr;
   logic [ADDR_W-1:0] blk_base;
   sfe_size_t blk_size;
   logic [SECT_W-1:0] sect;

   // Link-clock receiver.
   sfe_link_rx u_rx (
      .i_sck(i_sck),
      .i_rstn(i_rstn),
      .i_cs_n(i_cs_n),
      .i_si(i_si),
      .frm(frm.rx)
   );

   // Erase duration timer, started by the registered go pulse.
   sfe_erase_timer u_tmr (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_start(s_r.go),
      .i_cycles(tmr_cycles),
      .o_done(tmr_done)
   );

   // Erase time by region size.
   always_comb begin
      tmr_cycles = CHIP_ERASE_CYC;
      if (s_r.size == SZ_PAGE) begin
         tmr_cycles = PAGE_ERASE_CYC;
      end else if (s_r.size == SZ_4K) begin
         tmr_cycles = BLK4K_ERASE_CYC;
      end else if (s_r.size == SZ_32K) begin
         tmr_cycles = BLK32K_ERASE_CYC;
      end else if (s_r.size == SZ_64K) begin
         tmr_cycles = BLK64K_ERASE_CYC;
      end
   end

   // Frame end is the synchronised rise of chip select. The frame fields are
   // written on the serial clock, which has stopped by then, so after the two
   // synchroniser stages they are stable and are read as a quasi-static word.
   // A frame with no serial clock edge does not flip the toggle and is ignored.
   assign cs_rise = s_r.cs_s & ~s_r.cs_d;
   assign new_frame = s_r.tg_s != s_r.tg_seen;
   assign aligned = frm.bitc == 3'h0;
   assign op = frm.opcode;
   assign nb = frm.nbytes;

   // Opcode classes; both chip erase codes behave the same.
   assign is_page = op == OP_PAGE_ERASE;
   assign is_blk = op == OP_BLK_4K || op == OP_BLK_32K || op == OP_BLK_64K;
   assign is_chip = op == OP_CHIP_A || op == OP_CHIP_B;
   assign is_addr_erase = is_page | is_blk;

   // Address taken from the three bytes after the opcode; upper bits beyond
   // the array are ignored. The page frame carries the index in bytes 1 and 2.
   assign addr = {frm.byte1[1:0], frm.byte2, frm.byte3};
   assign page_addr = {frm.byte1[1:0], frm.byte2, 8'h00};

   // Block base with the low address bits dropped by block size.
   always_comb begin
      blk_base = addr;
      blk_size = SZ_64K;
      if (op == OP_BLK_4K) begin
         blk_base[BLK4K_LSB-1:0] = '0;
         blk_size = SZ_4K;
      end else if (op == OP_BLK_32K) begin
         blk_base[BLK32K_LSB-1:0] = '0;
         blk_size = SZ_32K;
      end else begin
         blk_base[BLK64K_LSB-1:0] = '0;
      end
   end

   // The sector holding the page or block; every region fits in one sector.
   assign sect = is_page ? page_addr[ADDR_W-1:SECT_LSB] : addr[ADDR_W-1:SECT_LSB];

   // Sequencer next state.
   always_comb begin
      s_nxt = s_r;
      // Two-stage synchronisers for chip select, frame toggle and status arm.
      s_nxt.cs_m = i_cs_n;
      s_nxt.cs_s = s_r.cs_m;
      s_nxt.cs_d = s_r.cs_s;
      s_nxt.tg_m = frm.toggle;
      s_nxt.tg_s = s_r.tg_m;
      s_nxt.as_m = frm.asi_armed;
      s_nxt.as_s = s_r.as_m;
      s_nxt.go = 1'b0;

      // Software-side protection update; the bits reset to all protected.
      if (i_prot_wr) begin
         s_nxt.prot = i_prot_val;
      end

      // Each finished frame is consumed once, busy or not.
      if (cs_rise) begin
         s_nxt.tg_seen = s_r.tg_s;
      end

      case (s_r.st)
         ST_IDLE: begin
            if (cs_rise && new_frame) begin
               if (!aligned) begin
                  // Deselect off a byte boundary: nothing runs, and an erase
                  // whose opcode arrived drops the latch.
                  if (nb != 3'h0 && (is_addr_erase || is_chip)) begin
                     s_nxt.write_enable_latch = 1'b0;
                  end
               end else if (nb == 3'h0) begin
                  // No complete opcode: ignored.
                  s_nxt.write_enable_latch = s_r.write_enable_latch;
               end else if (op == OP_WR_ENABLE) begin
                  s_nxt.write_enable_latch = 1'b1;
               end else if (op == OP_WR_DISABLE) begin
                  s_nxt.write_enable_latch = 1'b0;
               end else if (is_addr_erase) begin
                  if (!s_r.write_enable_latch) begin
                     s_nxt.write_enable_latch = 1'b0;
                  end else if (nb < ADDR_FRAME_BYTES) begin
                     s_nxt.write_enable_latch = 1'b0;
                  end else if (s_r.prot[sect]) begin
                     s_nxt.write_enable_latch = 1'b0;
                  end else begin
                     // Extra bytes past the address are ignored.
                     s_nxt.st = ST_ERASE;
                     s_nxt.go = 1'b1;
                     s_nxt.write_enable_latch = 1'b0;
                     s_nxt.erase_program_error_flag = 1'b0;
                     s_nxt.base = is_page ? page_addr : blk_base;
                     s_nxt.size = is_page ? SZ_PAGE : blk_size;
                  end
               end else if (is_chip) begin
                  if (!s_r.write_enable_latch) begin
                     s_nxt.write_enable_latch = 1'b0;
                  end else if (|s_r.prot) begin
                     s_nxt.write_enable_latch = 1'b0;
                  end else begin
                     // Address and data bytes after the opcode are ignored.
                     s_nxt.st = ST_ERASE;
                     s_nxt.go = 1'b1;
                     s_nxt.write_enable_latch = 1'b0;
                     s_nxt.erase_program_error_flag = 1'b0;
                     s_nxt.base = '0;
                     s_nxt.size = SZ_CHIP;
                  end
               end
            end
         end
         ST_ERASE: begin
            // Commands arriving while busy are dropped.
            if (tmr_done) begin
               s_nxt.st = ST_IDLE;
               s_nxt.erase_program_error_flag = s_r.erase_program_error_flag | i_erase_fail;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase

      // Active status: after sixteen clocks the output shows busy high and
      // falls as soon as the erase ends, for as long as chip select stays low.
      s_nxt.so_oe = s_r.as_s & ~s_r.cs_s;
      s_nxt.so = (s_nxt.st == ST_ERASE);
   end

   // State register; protection resets to all sectors protected.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= '{
            cs_m: 1'b1,
            cs_s: 1'b1,
            cs_d: 1'b1,
            tg_m: 1'b0,
            tg_s: 1'b0,
            tg_seen: 1'b0,
            as_m: 1'b0,
            as_s: 1'b0,
            st: ST_IDLE,
            write_enable_latch: 1'b0,
            erase_program_error_flag: 1'b0,
            prot: PROT_RST,
            go: 1'b0,
            base: '0,
            size: SZ_PAGE,
            so: 1'b0,
            so_oe: 1'b0
         };
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs, each straight from a flip-flop.
   assign o_so = s_r.so;
   assign o_so_oe = s_r.so_oe;
   assign o_busy = s_r.st[1];
   assign o_write_enable_latch = s_r.write_enable_latch;
   assign o_erase_program_error_flag = s_r.erase_program_error_flag;
   assign o_sector_prot = s_r.prot;
   assign o_erase_go = s_r.go;
   assign o_erase_base = s_r.base;
   assign o_erase_size = s_r.size;
endmodule : sfe_erase_seq

// File: hw/sfe_pkg.sv
// Constants, types and encodings shared by the serial flash erase sequencer.
// Assumes a 100 MHz system clock and an SPI mode 0 host on the link side.
// Behaviour
// - Array is 1024 pages of 256 bytes, chosen by a ten-bit page index.
// - Page erase frame: 81h, then page index top bits, low bits, dummy byte.
// - Page erase starts on chip select rise, self-timed, busy shown meanwhile.
// - Erase failure reported by the array sets the erase/program error flag.
// - Opcodes 20h, 52h, D8h erase 4, 32 and 64 kByte blocks.
// - Block erase runs only when the write enable latch was set first.
// - Block erase takes three address bytes, ignores extra bytes, starts on deselect.
// - Block base ignores address bits 11..0, 14..0 or 15..0 by size.
// - Short address or off-boundary deselect aborts block erase without erasing.
// - Protected target region blocks the erase; device returns to idle.
// - Block erase abort for any cause clears the write enable latch.
// - Busy shown during a good erase; latch cleared before erase ends.
// - Command 25h: after sixteen clocks, serial output goes low when busy ends.
// - Opcodes 60h and C7h both start the same chip erase.
// - Chip erase runs only when the write enable latch was set first.
// - Chip erase takes no address, ignores data, erases all on deselect.
// - Chip erase skipped on any protected sector, short opcode or off-boundary deselect.
// - Chip erase off-boundary or protection refusal clears the write enable latch.
// - Complete 06h frame ending on a byte boundary sets the latch.
// - Every sector protection bit resets to one, meaning protected.
package sfe_pkg;
   // Array geometry.
   localparam int ADDR_W = 18;
   localparam int PAGE_IDX_W = 10;
   localparam int PAGE_LSB = 8;
   localparam int SECT_W = 2;
   localparam int NUM_SECT = 4;
   localparam int SECT_LSB = 16;
   localparam int BLK4K_LSB = 12;
   localparam int BLK32K_LSB = 15;
   localparam int BLK64K_LSB = 16;
   localparam logic [NUM_SECT-1:0] PROT_RST = 4'hf;
   // Opcodes.
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   localparam logic [7:0] OP_BLK_4K = 8'h20;
   localparam logic [7:0] OP_BLK_32K = 8'h52;
   localparam logic [7:0] OP_BLK_64K = 8'hd8;
   localparam logic [7:0] OP_CHIP_A = 8'h60;
   localparam logic [7:0] OP_CHIP_B = 8'hc7;
   localparam logic [7:0] OP_WR_ENABLE = 8'h06;
   localparam logic [7:0] OP_WR_DISABLE = 8'h04;
   localparam logic [7:0] OP_ACT_STATUS = 8'h25;
   // Frame lengths in whole bytes.
   localparam logic [2:0] ADDR_FRAME_BYTES = 3'h4;
   localparam logic [2:0] ASI_ARM_BYTES = 3'h2;
   localparam logic [2:0] BYTES_MAX = 3'h7;
   // Erase times in microseconds and the clock rate in cycles per microsecond.
   localparam int unsigned CLK_PER_US = 100;
   localparam int unsigned PAGE_ERASE_TIME_US = 10000;
   localparam int unsigned BLK4K_ERASE_TIME_US = 50000;
   localparam int unsigned BLK32K_ERASE_TIME_US = 400000;
   localparam int unsigned BLK64K_ERASE_TIME_US = 800000;
   localparam int unsigned CHIP_ERASE_TIME_US = 4000000;
   // Erase region sizes.
   typedef enum logic [2:0] {
      SZ_PAGE = 3'h0,
      SZ_4K = 3'h1,
      SZ_32K = 3'h2,
      SZ_64K = 3'h3,
      SZ_CHIP = 3'h4
   } sfe_size_t;
   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ERASE = 2'b10
   } sfe_state_t;
endpackage : sfe_pkg

// File: hw/sfe_frame_if.sv
// Frame fields passed from the link receiver to the command sequencer.
// Fields are written on the serial clock; all but the status arm are read only after deselect has settled.
`timescale 1ns/100ps
interface sfe_frame_if;
   logic [7:0] opcode;
   logic [7:0] byte1;
   logic [7:0] byte2;
   logic [7:0] byte3;
   logic [2:0] nbytes;
   logic [2:0] bitc;
   logic toggle;
   logic asi_armed;
   // Receiver drives, sequencer reads.
   modport rx (output opcode, byte1, byte2, byte3, nbytes, bitc, toggle, asi_armed);
   modport core (input opcode, byte1, byte2, byte3, nbytes, bitc, toggle, asi_armed);
endinterface : sfe_frame_if

// File: hw/sfe_link_rx.sv
// Serial receiver on the link clock: shifts in bytes, counts bits and bytes.
// Assumes SPI mode 0 with data sampled on the rising serial clock edge.
`timescale 1ns/100ps
module sfe_link_rx import sfe_pkg::*; (
   // Link pins.
   input wire logic i_sck,
   input wire logic i_rstn,
   input wire logic i_cs_n,
   input wire logic i_si,
   // Frame fields.
   sfe_frame_if.rx frm
);
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] bitc;
      logic [2:0] nbytes;
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic tog;
   } sfe_rx_t;
   sfe_rx_t s_r;
   sfe_rx_t s_nxt;
   logic first_r;
   logic asi_r;
   logic sel_rst_n;
   logic [7:0] sh_nxt;
   logic [2:0] bc;
   logic [2:0] nb;

   // Deselect marks the next edge as a frame start and drops the status arm.
   assign sel_rst_n = i_rstn & ~i_cs_n;

   // Next state: shift a bit, store completed bytes by position.
   always_comb begin
      s_nxt = s_r;
      bc = first_r ? 3'h0 : s_r.bitc;
      nb = first_r ? 3'h0 : s_r.nbytes;
      sh_nxt = {s_r.sh[6:0], i_si};
      s_nxt.sh = sh_nxt;
      s_nxt.bitc = bc + 3'h1;
      s_nxt.nbytes = nb;
      if (first_r) begin
         s_nxt.tog = ~s_r.tog;
      end
      if (bc == 3'h7) begin
         if (nb != BYTES_MAX) begin
            s_nxt.nbytes = nb + 3'h1;
         end
         if (nb == 3'h0) begin
            s_nxt.op = sh_nxt;
         end else if (nb == 3'h1) begin
            s_nxt.b1 = sh_nxt;
         end else if (nb == 3'h2) begin
            s_nxt.b2 = sh_nxt;
         end else if (nb == 3'h3) begin
            s_nxt.b3 = sh_nxt;
         end
      end
   end

   // Frame data holds its value after deselect for the sequencer to read.
   always_ff @(posedge i_sck or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Frame-start flag set and status arm cleared whenever chip select is high.
   always_ff @(posedge i_sck or negedge sel_rst_n) begin
      if (!sel_rst_n) begin
         first_r <= 1'b1;
         asi_r <= 1'b0;
      end else begin
         first_r <= 1'b0;
         asi_r <= asi_r | (s_nxt.op == OP_ACT_STATUS && s_nxt.nbytes >= ASI_ARM_BYTES);
      end
   end

   assign frm.opcode = s_r.op;
   assign frm.byte1 = s_r.b1;
   assign frm.byte2 = s_r.b2;
   assign frm.byte3 = s_r.b3;
   assign frm.nbytes = s_r.nbytes;
   assign frm.bitc = s_r.bitc;
   assign frm.toggle = s_r.tog;
   assign frm.asi_armed = asi_r;
endmodule : sfe_link_rx

// File: hw/sfe_erase_timer.sv
// Self-timed erase duration counter on the system clock.
// Assumes i_cycles is at least one and stable while i_start is high.
`timescale 1ns/100ps
module sfe_erase_timer (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rstn,
   // Control.
   input wire logic i_start,
   input wire logic [31:0] i_cycles,
   output logic o_done
);
   typedef struct packed {
      logic [31:0] cnt;
      logic run;
      logic done;
   } sfe_tmr_t;
   sfe_tmr_t t_r;
   sfe_tmr_t t_nxt;

   // Load on start, count down, pulse done on the last cycle.
   always_comb begin
      t_nxt = t_r;
      t_nxt.done = 1'b0;
      if (i_start) begin
         t_nxt.cnt = i_cycles;
         t_nxt.run = 1'b1;
      end else if (t_r.run) begin
         t_nxt.cnt = t_r.cnt - 32'h1;
         if (t_r.cnt <= 32'h1) begin
            t_nxt.run = 1'b0;
            t_nxt.done = 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         t_r <= '0;
      end else begin
         t_r <= t_nxt;
      end
   end

   assign o_done = t_r.done;
endmodule : sfe_erase_timer

// File: verif/sfe_host_model.sv
// SPI host model for the erase sequencer: mode 0 frames on a 160 ns serial clock.
// Assumes the bench calls frame() and end_frame() by hierarchical reference.
`timescale 1ns/100ps
module sfe_host_model (
   // Link pins.
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si
);
   // Idle link: clock stands still, device deselected.
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   // Sends n bits of d, MSB first; keep leaves the device selected afterwards.
   task automatic frame(input logic [39:0] d, input int n, input bit keep);
      #3.3 o_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         o_si = d[39-i];
         #80 o_sck = 1'b1;
         #80 o_sck = 1'b0;
      end
      if (!keep) end_frame();
   endtask : frame
   // Deselects, then flips the released data line so no stale level lingers.
   task automatic end_frame();
      #80 o_cs_n = 1'b1;
      o_si = ~o_si;
      #100;
   endtask : end_frame
endmodule : sfe_host_model

// File: verif/sfe_erase_seq_assertions.sv
// Concurrent checks on the erase sequencer's top-level ports.
// Assumes all watched outputs are registers on i_clk; bound at the file foot.
`timescale 1ns/100ps
module sfe_erase_seq_assertions import sfe_pkg::*; (
   // Clock, reset and link.
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic o_so,
   input wire logic o_so_oe,
   // Status.
   input wire logic o_busy,
   input wire logic o_write_enable_latch,
   input wire logic o_erase_program_error_flag,
   // Protection.
   input wire logic i_prot_wr,
   input wire logic [NUM_SECT-1:0] i_prot_val,
   input wire logic [NUM_SECT-1:0] o_sector_prot,
   // Array port.
   input wire logic o_erase_go,
   input wire logic [ADDR_W-1:0] o_erase_base,
   input wire logic [2:0] o_erase_size
);
   // All checks live in the system clock domain.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_go_pulse; o_erase_go |=> !o_erase_go; endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("go longer than one cycle");
   property p_go_state; o_erase_go |-> o_busy && !o_write_enable_latch; endproperty
   a_go_state: assert property (p_go_state) else $error("go without busy or with latch set");
   property p_busy_cause; $rose(o_busy) |-> o_erase_go; endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy rose without go");
   property p_busy_hold; $rose(o_busy) |=> o_busy [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped too early");
   property p_region_prot; o_erase_go && o_erase_size != 3'h4 |-> !o_sector_prot[o_erase_base[17:16]]; endproperty
   a_region_prot: assert property (p_region_prot) else $error("erase in protected sector");
   property p_chip_prot; o_erase_go && o_erase_size == 3'h4 |-> o_sector_prot == 4'h0; endproperty
   a_chip_prot: assert property (p_chip_prot) else $error("chip erase with a protected sector");
   property p_align;
      o_erase_go |-> (o_erase_size != 3'h0 || o_erase_base[7:0] == 8'h00)
         && (o_erase_size != 3'h1 || o_erase_base[11:0] == 12'h000)
         && (o_erase_size != 3'h2 || o_erase_base[14:0] == 15'h0000)
         && (o_erase_size != 3'h3 || o_erase_base[15:0] == 16'h0000);
   endproperty
   a_align: assert property (p_align) else $error("erase base not aligned");
   property p_err_end; $rose(o_erase_program_error_flag) |-> $fell(o_busy); endproperty
   a_err_end: assert property (p_err_end) else $error("error flag set outside erase end");
   property p_so_end; o_so_oe && $fell(o_busy) |-> !o_so; endproperty
   a_so_end: assert property (p_so_end) else $error("serial out not low at erase end");
   property p_prot_load; i_prot_wr |=> o_sector_prot == $past(i_prot_val); endproperty
   a_prot_load: assert property (p_prot_load) else $error("protection bits not loaded");
   c_page: cover property (o_erase_go && o_erase_size == 3'h0);
   c_chip: cover property (o_erase_go && o_erase_size == 3'h4);
   c_so: cover property (o_so_oe && $fell(o_busy));
endmodule : sfe_erase_seq_assertions
bind sfe_erase_seq sfe_erase_seq_assertions u_chk (.i_clk, .i_rstn, .o_so, .o_so_oe, .o_busy,
   .o_write_enable_latch, .o_erase_program_error_flag, .i_prot_wr, .i_prot_val, .o_sector_prot,
   .o_erase_go, .o_erase_base, .o_erase_size);

// File: verif/sfe_erase_seq_bench.sv
// Self-checking bench for the erase sequencer with an SPI host model.
// Assumes short erase times; the 64 kByte count is long enough for a status frame.
`timescale 1ns/100ps
module sfe_erase_seq_bench;
   import sfe_pkg::*;
   logic i_clk, i_rstn, i_prot_wr, i_erase_fail, sck, cs_n, si, o_so, o_so_oe, o_busy, write_enable_latch, err, go;
   logic [NUM_SECT-1:0] i_prot_val, prot;
   logic [ADDR_W-1:0] base;
   logic [2:0] size;
   logic [21:0] notes[$];
   logic [21:0] n;
   logic [23:0] a;
   logic fail;
   int mismatches, checked, seed, k;
   logic [7:0] op[4] = '{8'h81, 8'h20, 8'h52, 8'hd8};
   logic [7:0] rop[6] = '{8'hd8, 8'h60, 8'hd8, 8'h20, 8'h81, 8'hc7};
   int rn[6] = '{32, 8, 24, 35, 16, 12};
   bit rw[6] = '{0, 0, 1, 1, 1, 1};
   sfe_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
   sfe_erase_seq #(.PAGE_ERASE_CYC(40), .BLK4K_ERASE_CYC(40), .BLK32K_ERASE_CYC(40),
      .BLK64K_ERASE_CYC(1000), .CHIP_ERASE_CYC(40)) DUT (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy),
      .o_write_enable_latch(write_enable_latch), .o_erase_program_error_flag(err), .i_prot_wr(i_prot_wr),
      .i_prot_val(i_prot_val), .o_sector_prot(prot), .o_erase_go(go), .o_erase_base(base),
      .o_erase_size(size), .i_erase_fail(i_erase_fail));
   // System clock, 100 MHz.
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Compares one value and counts the result.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      if (notes.size() != 0) mismatches++;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   // Sets the write enable latch.
   task automatic wen();
      host.frame({OP_WR_ENABLE, 32'h0}, 8, 0);
   endtask : wen
   // Polls busy until the erase ends, within a bound.
   task automatic wait_idle();
      for (k = 0; k < 3000 && o_busy !== 1'b0; k++) @(negedge i_clk);
      if (k == 3000) begin
         mismatches++;
         finish_test();
      end
      @(negedge i_clk);
   endtask : wait_idle
   // Loads the sector protection bits.
   task automatic set_prot(input logic [3:0] v);
      @(negedge i_clk);
      i_prot_val = v;
      i_prot_wr = 1'b1;
      @(negedge i_clk);
      i_prot_wr = 1'b0;
      chk(prot, v);
   endtask : set_prot
   // Every erase start is matched against the oldest expected region.
   always @(negedge i_clk) begin
      if (go === 1'b1) begin
         if (notes.size() == 0) begin
            chk(go, 1'b0);
         end else begin
            n = notes.pop_front();
            chk(size, n[2:0]);
            if (n[21]) chk(base, n[20:3]);
         end
      end
   end
   // Main sequence.
   initial begin
      seed = 25;
      i_rstn = 1'b0;
      i_prot_wr = 1'b0;
      i_prot_val = 4'h0;
      i_erase_fail = 1'b0;
      repeat (6) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (4) @(negedge i_clk);
      chk(prot, 4'hf);
      chk({o_busy, write_enable_latch, err}, 3'h0);
      wen();
      host.frame({8'h20, 32'h0}, 32, 0);
      chk(write_enable_latch, 1'b0);
      set_prot(4'h0);
      for (int i = 0; i < 4; i++) begin
         a = $random(seed);
         // The second erase always reports a verify failure so the error path is exercised.
         fail = 1'($random(seed)) | (i == 1);
         i_erase_fail = fail;
         wen();
         notes.push_back({1'b1, a[17:0] & ~((18'h1 << (i == 0 ? 8 : i == 1 ? 12 : i == 2 ? 15 : 16)) - 18'h1),
            3'(i)});
         host.frame({op[i], a, 8'h5a}, i == 3 ? 40 : 32, 0);
         wait_idle();
         chk(err, fail);
         chk(write_enable_latch, 1'b0);
      end
      i_erase_fail = 1'b0;
      for (int i = 0; i < 2; i++) begin
         wen();
         notes.push_back({19'h0, 3'h4});
         host.frame({i ? OP_CHIP_B : OP_CHIP_A, 32'ha5a5a5a5}, 8 + 8 * i, 0);
         wait_idle();
      end
      for (int i = 0; i < 6; i++) begin
         if (rw[i]) wen();
         host.frame({rop[i], 32'h0}, rn[i], 0);
         chk(write_enable_latch, 1'b0);
      end
      host.frame({8'h06, 32'h0}, 7, 0);
      chk(write_enable_latch, 1'b0);
      host.frame({8'h06, 32'hffffffff}, 16, 0);
      chk(write_enable_latch, 1'b1);
      // Write disable drops the latch; it is set again for the refusal below.
      host.frame({OP_WR_DISABLE, 32'h0}, 8, 0);
      chk(write_enable_latch, 1'b0);
      wen();
      set_prot(4'h2);
      host.frame({OP_CHIP_A, 32'h0}, 8, 0);
      chk(write_enable_latch, 1'b0);
      set_prot(4'h0);
      wen();
      notes.push_back({1'b1, 18'h30000, 3'h3});
      host.frame({8'hd8, 24'h03fedc, 8'h00}, 32, 0);
      host.frame({8'h25, 32'h0}, 16, 1);
      repeat (5) @(negedge i_clk);
      chk({o_so_oe, o_so}, 2'h3);
      wait_idle();
      chk({o_so_oe, o_so}, 2'h2);
      host.end_frame();
      finish_test();
   end
endmodule : sfe_erase_seq_bench
